// >>> verilog/cu_buffer_source_sel_regs.sv
// transmitter source select control register and transmitter status register
// Summary of operation
// R1: source field 00 none, 01 host, 10 receiver
// R2: source 11: host first 10 bytes, rest receiver
// R3: validity select 0 uses control validity bit
// R4: validity select 1 passes receiver bit directly
// R5: copy-done flag sets when enabled and unmasked
// R6: copy-done flag lowers interrupt, sets summary bit
// R7: slip flag sets on slip/blockstart when unmasked
// R8: select bit picks slips or block starts
// R9: slip flag lowers interrupt, sets summary bit
// R10: status read-only, bits 7..2 read zero
// R11: buffer updates only with nonzero source field
// R12: disable bit suspends copies; clearing re-enables
// R13: slip unmask resets to 0, masked
// R14: host reads flags anytime; control host-written only
`timescale 1ns/1ps
`include "cu_buffer_source_sel_consts.svh"
module cu_buffer_source_sel_regs (
    input wire logic clk,
    input wire logic resetn,
    input cu_buffer_source_sel_pkg::cu_buffer_source_sel_req_t host_req,
    output logic [7:0] host_rdata,
    input wire logic host_byte_we,
    input wire logic [7:0] host_byte_index,
    input wire logic recv_byte_valid,
    input wire logic [7:0] recv_byte_index,
    output cu_buffer_source_sel_pkg::cu_buffer_source_sel_load_t ua_load,
    input wire logic ctrl_validity,
    input wire logic recv_validity,
    output logic tx_validity,
    input wire logic copy_done,
    input wire logic copy_disable,
    input wire logic copy_unmask,
    input wire logic slip_event,
    input wire logic blockstart_event,
    input wire logic slip_or_blockstart_sel,
    input wire logic slip_unmask,
    output logic summary_tx,
    output logic irq_n
);
    import cu_buffer_source_sel_pkg::*;
    // ****************************************
    // control register
    // ****************************************
    logic [7:0] ctrl3;
    logic [2:0] next_ctrl3_bits;
    wire wr_ctrl3 = host_req.wr && (host_req.addr == `CU_BUFFER_SOURCE_SEL_OFF_CTRL3);
    wire rd_status = host_req.rd && (host_req.addr == `CU_BUFFER_SOURCE_SEL_OFF_STATUS);
    assign next_ctrl3_bits = wr_ctrl3 ? host_req.wdata[2:0] : ctrl3[2:0]; // [R14]
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl3 <= `CU_BUFFER_SOURCE_SEL_CTRL3_RESET;
        end else begin
            ctrl3 <= {5'h00, next_ctrl3_bits};
        end
    end
    wire [1:0] src_bits = ctrl3[`CU_BUFFER_SOURCE_SEL_BIT_SRC_HI:`CU_BUFFER_SOURCE_SEL_BIT_SRC_LO];
    cu_buffer_source_sel_src_t src;
    assign src = cu_buffer_source_sel_src_t'(src_bits);
    // ****************************************
    // user-access buffer load steering
    // ****************************************
    function automatic logic below_split(input logic [7:0] idx);
        below_split = idx < `CU_BUFFER_SOURCE_SEL_SPLIT_BYTES;
    endfunction
    wire host_ok = (src == CU_BUFFER_SOURCE_SEL_SRC_HOST) ||
                   ((src == CU_BUFFER_SOURCE_SEL_SRC_SPLIT) && below_split(host_byte_index)); // [R1] [R2]
    wire recv_ok = (src == CU_BUFFER_SOURCE_SEL_SRC_RECV) ||
                   ((src == CU_BUFFER_SOURCE_SEL_SRC_SPLIT) && !below_split(recv_byte_index)); // [R1] [R2]
    wire next_host_we = host_byte_we && host_ok; // [R11]
    wire next_recv_we = recv_byte_valid && recv_ok && !next_host_we; // [R11]
    wire [7:0] next_index = next_host_we ? host_byte_index : recv_byte_index;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ua_load <= '0;
        end else begin
            ua_load <= '{host_we: next_host_we, recv_we: next_recv_we, index: next_index};
        end
    end
    // validity goes straight through: no flop, so no added latency
    assign tx_validity = ctrl3[`CU_BUFFER_SOURCE_SEL_BIT_VALSRC] ? recv_validity : ctrl_validity; // [R3] [R4]
    // ****************************************
    // status flags and interrupt
    // ****************************************
    logic [1:0] flags;
    // flags clear when the host reads the status register
    cu_buffer_source_sel_status_flags u_flags (
        .clk(clk),
        .resetn(resetn),
        .copy_done(copy_done),
        .copy_disable(copy_disable), // [R12]
        .copy_unmask(copy_unmask),
        .slip_event(slip_event),
        .blockstart_event(blockstart_event),
        .slip_or_blockstart_sel(slip_or_blockstart_sel),
        .slip_unmask(slip_unmask),
        .clear(rd_status),
        .flags(flags)
    );
    assign summary_tx = |flags; // [R6] [R9]
    assign irq_n = ~summary_tx; // [R6] [R9]
    wire [7:0] next_rdata = wr_ctrl3 ? 8'h00 :
                            (host_req.rd && host_req.addr == `CU_BUFFER_SOURCE_SEL_OFF_CTRL3) ? ctrl3 :
                            rd_status ? {6'h00, flags} : 8'h00; // [R10] [R14]
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            host_rdata <= 8'h00;
        end else begin
            host_rdata <= next_rdata;
        end
    end
    // ****************************************
    // checks
    // ****************************************
    src_none_a: assert property (@(posedge clk) disable iff (!resetn)
        (src == CU_BUFFER_SOURCE_SEL_SRC_NONE) |=> !ua_load.host_we && !ua_load.recv_we)
        else $error("load with source none"); // [R11]
    split_host_a: assert property (@(posedge clk) disable iff (!resetn)
        (src == CU_BUFFER_SOURCE_SEL_SRC_SPLIT && host_byte_we && host_byte_index >= 8'h0a) |=> !ua_load.host_we)
        else $error("host wrote past split"); // [R2]
    recv_only_a: assert property (@(posedge clk) disable iff (!resetn)
        (src == CU_BUFFER_SOURCE_SEL_SRC_RECV && host_byte_we) |=> !ua_load.host_we)
        else $error("host load in receiver mode"); // [R1]
    val_sel_a: assert property (@(posedge clk) disable iff (!resetn)
        tx_validity == (ctrl3[2] ? recv_validity : ctrl_validity))
        else $error("validity source wrong"); // [R3]
    irq_pin_a: assert property (@(posedge clk) disable iff (!resetn)
        $rose(flags[0] | flags[1]) |-> !irq_n && summary_tx) else $error("irq not low"); // [R6]
    status_zero_a: assert property (@(posedge clk) disable iff (!resetn)
        rd_status |=> host_rdata[7:2] == 6'h00) else $error("status high bits set"); // [R10]
    ctrl_hold_a: assert property (@(posedge clk) disable iff (!resetn)
        !wr_ctrl3 |=> $stable(ctrl3)) else $error("control changed without write"); // [R14]
    // load steering seen from the offer side, written from the source table rather than
    // from the steering wires, so a slip in host_ok or recv_ok is caught here
    host_wins_a: assert property (@(posedge clk) disable iff (!resetn) // [R2]
        (host_byte_we && recv_byte_valid && src == CU_BUFFER_SOURCE_SEL_SRC_SPLIT && host_byte_index < 8'h0a)
        |=> ua_load.host_we && !ua_load.recv_we) else $error("host lost a collision");
    host_index_a: assert property (@(posedge clk) disable iff (!resetn) // [R1]
        (src == CU_BUFFER_SOURCE_SEL_SRC_HOST && host_byte_we)
        |=> ua_load.host_we && ua_load.index == $past(host_byte_index))
        else $error("host load index wrong");
    recv_mode_a: assert property (@(posedge clk) disable iff (!resetn) // [R1]
        (src == CU_BUFFER_SOURCE_SEL_SRC_RECV && recv_byte_valid)
        |=> ua_load.recv_we && !ua_load.host_we) else $error("receiver load missing");
    split_recv_a: assert property (@(posedge clk) disable iff (!resetn) // [R2]
        (src == CU_BUFFER_SOURCE_SEL_SRC_SPLIT && recv_byte_valid && !host_byte_we && recv_byte_index >= 8'h0a)
        |=> ua_load.recv_we) else $error("receiver load past split missing");
    // register reads
    ctrl_read_a: assert property (@(posedge clk) disable iff (!resetn) // [R14]
        (host_req.rd && host_req.addr == 8'h09)
        |=> host_rdata == {5'h00, $past(ctrl3[2:0])}) else $error("control readback wrong");
    status_read_a: assert property (@(posedge clk) disable iff (!resetn) // [R10]
        rd_status |=> host_rdata[1:0] == $past(flags)) else $error("status readback wrong");
    ctrl_pad_a: assert property (@(posedge clk) disable iff (!resetn) // [R14]
        ctrl3[7:3] == 5'h00) else $error("control upper bits set");
    // a read with no event pending must leave both flags clear
    flag_clear_a: assert property (@(posedge clk) disable iff (!resetn) // [R10]
        (rd_status && !copy_done && !slip_event && !blockstart_event)
        |=> flags == 2'b00) else $error("flags survived status read");
    // interrupt pin follows the flags in both directions
    irq_slip_a: assert property (@(posedge clk) disable iff (!resetn) // [R9]
        flags[1] |-> !irq_n && summary_tx) else $error("slip did not raise interrupt");
    irq_idle_a: assert property (@(posedge clk) disable iff (!resetn) // [R6]
        (flags == 2'b00) |-> irq_n && !summary_tx) else $error("interrupt without flag");
    c_split: cover property (@(posedge clk) src == CU_BUFFER_SOURCE_SEL_SRC_SPLIT && ua_load.recv_we);
    c_status_rd: cover property (@(posedge clk) rd_status && flags == 2'b11);
    c_irq: cover property (@(posedge clk) $fell(irq_n));
endmodule

// >>> verilog/cu_buffer_source_sel_consts.svh
// constants for the transmitter source select and status registers
`ifndef CU_BUFFER_SOURCE_SEL_CONSTS_SVH
`define CU_BUFFER_SOURCE_SEL_CONSTS_SVH
`define CU_BUFFER_SOURCE_SEL_OFF_CTRL3 8'h09
`define CU_BUFFER_SOURCE_SEL_OFF_STATUS 8'h0a
`define CU_BUFFER_SOURCE_SEL_CTRL3_RESET 8'h00
`define CU_BUFFER_SOURCE_SEL_BIT_SRC_LO 0
`define CU_BUFFER_SOURCE_SEL_BIT_SRC_HI 1
`define CU_BUFFER_SOURCE_SEL_BIT_VALSRC 2
`define CU_BUFFER_SOURCE_SEL_BIT_COPY_DONE 0
`define CU_BUFFER_SOURCE_SEL_BIT_SLIP 1
`define CU_BUFFER_SOURCE_SEL_SPLIT_BYTES 8'h0a
`endif

// >>> verilog/cu_buffer_source_sel_pkg.sv
// types for the transmitter source select and status registers
package cu_buffer_source_sel_pkg;
    typedef enum logic [1:0] {
        CU_BUFFER_SOURCE_SEL_SRC_NONE = 2'b00,
        CU_BUFFER_SOURCE_SEL_SRC_HOST = 2'b01,
        CU_BUFFER_SOURCE_SEL_SRC_RECV = 2'b10,
        CU_BUFFER_SOURCE_SEL_SRC_SPLIT = 2'b11
    } cu_buffer_source_sel_src_t;
    // host port register access, one cycle per access
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cu_buffer_source_sel_req_t;
    // byte offered to the user-access buffer from either side
    typedef struct packed {
        logic host_we;
        logic recv_we;
        logic [7:0] index;
    } cu_buffer_source_sel_load_t;
endpackage

// >>> verilog/cu_buffer_source_sel_status_flags.sv
// sticky status flags with unmask gating
`timescale 1ns/1ps
`include "cu_buffer_source_sel_consts.svh"
module cu_buffer_source_sel_status_flags (
    input wire logic clk,
    input wire logic resetn,
    input wire logic copy_done,
    input wire logic copy_disable,
    input wire logic copy_unmask,
    input wire logic slip_event,
    input wire logic blockstart_event,
    input wire logic slip_or_blockstart_sel,
    input wire logic slip_unmask,
    input wire logic clear,
    output logic [1:0] flags
);
    import cu_buffer_source_sel_pkg::*;
    wire set_copy = copy_done & ~copy_disable & copy_unmask; // [R5] [R12]
    wire slip_src = slip_or_blockstart_sel ? blockstart_event : slip_event; // [R8]
    wire set_slip = slip_src & slip_unmask; // [R7] [R13]
    logic [1:0] next_flags;
    // set wins over a clear-on-read in the same cycle
    assign next_flags = (clear ? 2'b00 : flags) | {set_slip, set_copy};
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            flags <= 2'b00;
        end else begin
            flags <= next_flags;
        end
    end
    copy_set_a: assert property (@(posedge clk) disable iff (!resetn)
        set_copy |=> flags[`CU_BUFFER_SOURCE_SEL_BIT_COPY_DONE]) else $error("copy flag not set"); // [R5]
    copy_block_a: assert property (@(posedge clk) disable iff (!resetn)
        (copy_disable && !flags[0] && !$past(set_copy)) |=> !flags[0] || $past(copy_done && !copy_disable))
        else $error("copy flag set while disabled"); // [R12]
    slip_set_a: assert property (@(posedge clk) disable iff (!resetn)
        set_slip |=> flags[`CU_BUFFER_SOURCE_SEL_BIT_SLIP]) else $error("slip flag not set"); // [R7]
    slip_mask_a: assert property (@(posedge clk) disable iff (!resetn)
        (!slip_unmask && (clear || !flags[1])) |=> !flags[1]) else $error("masked slip set"); // [R13]
    c_copy: cover property (@(posedge clk) set_copy);
    c_slip: cover property (@(posedge clk) set_slip && slip_or_blockstart_sel);
endmodule

// >>> dv/cu_buffer_source_sel_host_model.sv
// host-side model that drives the register port of the block
`timescale 1ns/1ps
module cu_buffer_source_sel_host_model (
    input wire logic clk,
    output cu_buffer_source_sel_pkg::cu_buffer_source_sel_req_t host_req
);
    import cu_buffer_source_sel_pkg::*;
    initial host_req = '0;
    // one-cycle pulse per access, launched just after an edge; any flag may be read at any time
    task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wdata);
        @(posedge clk);
        #1 host_req = '{wr: wr, rd: ~wr, addr: addr, wdata: wdata};
        @(posedge clk);
        #1 host_req = '0;
    endtask
endmodule

// >>> dv/cu_buffer_source_sel_regs_tb.sv
// self-checking bench for the transmitter source select and status registers
`timescale 1ns/1ps
module cu_buffer_source_sel_regs_tb;
    import cu_buffer_source_sel_pkg::*;
    logic clk, resetn, host_byte_we, recv_byte_valid, ctrl_validity, recv_validity, tx_validity;
    logic copy_done, copy_disable, copy_unmask, slip_event, blockstart_event, summary_tx, irq_n;
    logic slip_or_blockstart_sel, slip_unmask;
    logic [7:0] host_byte_index, recv_byte_index, host_rdata;
    cu_buffer_source_sel_req_t host_req;
    cu_buffer_source_sel_load_t ua_load;
    int num_errors = 0;
    int n_compared = 0;
    // rows: control value, host side offer, byte index, expected {host_we, recv_we}
    logic [18:0] rows [9] = '{{8'h00, 1'b1, 8'h03, 2'b00}, {8'h01, 1'b1, 8'h03, 2'b10},
        {8'h01, 1'b0, 8'h03, 2'b00}, {8'h02, 1'b0, 8'h03, 2'b01}, {8'h02, 1'b1, 8'h03, 2'b00},
        {8'h03, 1'b1, 8'h09, 2'b10}, {8'h03, 1'b1, 8'h0a, 2'b00}, {8'h03, 1'b0, 8'h0a, 2'b01},
        {8'h03, 1'b0, 8'h09, 2'b00}};
    cu_buffer_source_sel_host_model cu_buffer_source_sel_host_model_inst (.clk, .host_req);
    cu_buffer_source_sel_regs cu_buffer_source_sel_regs_inst (.clk, .resetn, .host_req, .host_rdata, .host_byte_we,
        .host_byte_index, .recv_byte_valid, .recv_byte_index, .ua_load, .ctrl_validity,
        .recv_validity, .tx_validity, .copy_done, .copy_disable, .copy_unmask, .slip_event,
        .blockstart_event, .slip_or_blockstart_sel, .slip_unmask, .summary_tx, .irq_n);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
        cu_buffer_source_sel_host_model_inst.access(1'b0, addr, 8'h00);
        check(host_rdata, exp);
    endtask
    task automatic offer(input logic host, input logic [7:0] idx, input logic [1:0] exp);
        @(posedge clk);
        #1 {host_byte_we, recv_byte_valid} = {host, ~host};
        {host_byte_index, recv_byte_index} = {idx, idx};
        @(posedge clk);
        #1 {host_byte_we, recv_byte_valid} = 2'b00;
        check({6'h00, ua_load.host_we, ua_load.recv_we}, {6'h00, exp});
        check(ua_load.index, idx);
    endtask
    // cfg: copy, slip, block start events, then disable, copy unmask, slip unmask, select
    task automatic ev_case(input logic [6:0] cfg, input logic [7:0] exp);
        @(posedge clk);
        #1 {copy_done, slip_event, blockstart_event, copy_disable, copy_unmask, slip_unmask,
            slip_or_blockstart_sel} = cfg;
        @(posedge clk);
        #1 {copy_done, slip_event, blockstart_event} = 3'b000;
        check({6'h00, summary_tx, irq_n}, {6'h00, |exp, ~|exp});
        rd(8'h0a, exp);
        rd(8'h0a, 8'h00);
    endtask
    task automatic give_verdict;
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {resetn, host_byte_we, recv_byte_valid, ctrl_validity, recv_validity, copy_done} = '0;
        {copy_disable, copy_unmask, slip_event, blockstart_event} = '0;
        {slip_or_blockstart_sel, slip_unmask, host_byte_index, recv_byte_index} = '0;
        repeat (6) @(posedge clk);
        #1 resetn = 1'b1;
        check({7'h00, irq_n}, 8'h01);
        rd(8'h09, 8'h00);
        rd(8'h0a, 8'h00);
        $display("test reset done");
        foreach (rows[i]) begin
            cu_buffer_source_sel_host_model_inst.access(1'b1, 8'h09, rows[i][18:11]);
            offer(rows[i][10], rows[i][9:2], rows[i][1:0]);
        end
        $display("test source table done");
        cu_buffer_source_sel_host_model_inst.access(1'b1, 8'h09, 8'h04);
        recv_validity = 1'b1;
        #1 check({7'h00, tx_validity}, 8'h01);
        cu_buffer_source_sel_host_model_inst.access(1'b1, 8'h09, 8'hf8);
        check({7'h00, tx_validity}, 8'h00);
        ctrl_validity = 1'b1;
        #1 check({7'h00, tx_validity}, 8'h01);
        rd(8'h09, 8'h00);
        cu_buffer_source_sel_host_model_inst.access(1'b1, 8'h0a, 8'hff);
        rd(8'h0a, 8'h00);
        $display("test validity and read-only done");
        ev_case(7'b100_0100, 8'h01);
        ev_case(7'b100_1100, 8'h00);
        ev_case(7'b100_0000, 8'h00);
        ev_case(7'b010_0010, 8'h02);
        ev_case(7'b001_0011, 8'h02);
        ev_case(7'b010_0011, 8'h00);
        ev_case(7'b010_0000, 8'h00);
        $display("test status flags done");
        // collision in split mode: host byte below the split and receiver byte above it
        cu_buffer_source_sel_host_model_inst.access(1'b1, 8'h09, 8'h03);
        @(posedge clk);
        #1 {host_byte_we, recv_byte_valid, host_byte_index, recv_byte_index} = {2'b11, 8'h03, 8'h0c};
        @(posedge clk);
        #1 {host_byte_we, recv_byte_valid} = 2'b00;
        check({6'h00, ua_load.host_we, ua_load.recv_we}, 8'h02);
        check(ua_load.index, 8'h03);
        // copy completes in the same cycle as the status read: the set must win
        copy_unmask = 1'b1;
        fork
            cu_buffer_source_sel_host_model_inst.access(1'b0, 8'h0a, 8'h00);
            begin
                @(posedge clk);
                #1 copy_done = 1'b1;
                @(posedge clk);
                #1 copy_done = 1'b0;
            end
        join
        check(host_rdata, 8'h00);
        check({7'h00, summary_tx}, 8'h01);
        // reset in mid-run with a flag pending and a nonzero control value
        cu_buffer_source_sel_host_model_inst.access(1'b1, 8'h09, 8'h07);
        @(posedge clk);
        #1 resetn = 1'b0;
        @(posedge clk);
        #1 resetn = 1'b1;
        check({7'h00, irq_n}, 8'h01);
        rd(8'h09, 8'h00);
        rd(8'h0a, 8'h00);
        $display("test collision and mid-run reset done");
        give_verdict();
    end
    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        give_verdict();
    end
endmodule
